// ==== design/ddp_pkg.sv ====
// Package for the dual data pointer and status word register file.
// Assumes one core clock domain and an 8-bit special-function register space.
package ddp_pkg;

  // Special-function register addresses
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_POINTER0_LOW_BYTE = 8'h82;
  localparam logic [7:0] ADDR_POINTER0_HIGH_BYTE = 8'h83;
  localparam logic [7:0] ADDR_POINTER1_LOW_BYTE = 8'h84;
  localparam logic [7:0] ADDR_POINTER1_HIGH_BYTE = 8'h85;
  localparam logic [7:0] ADDR_POINTER_CHOICE_REG = 8'h86;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_MAIN_WORK_REGISTER = 8'he0;
  localparam logic [7:0] ADDR_SECOND_OPERAND_REGISTER = 8'hf0;

  // Status word field positions
  localparam int unsigned POS_UNSIGNED_CARRY = 7;
  localparam int unsigned POS_NIBBLE_CARRY = 6;
  localparam int unsigned POS_USER_FLAG_ZERO = 5;
  localparam int unsigned POS_BANK_SELECT_HIGH = 4;
  localparam int unsigned POS_BANK_SELECT_LOW = 3;
  localparam int unsigned POS_SIGNED_WRAP = 2;
  localparam int unsigned POS_USER_FLAG_ONE = 1;
  localparam int unsigned POS_PARITY = 0;

  // Pointer choice bit position
  localparam int unsigned POS_POINTER_CHOICE = 0;

  // Reset values
  localparam logic [7:0] RST_STACK_POINTER = 8'h00;
  localparam logic [15:0] RST_POINTER = 16'h0000;
  localparam logic [7:0] RST_POINTER_CHOICE = 8'h00;
  localparam logic [7:0] RST_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_MAIN_WORK = 8'h00;
  localparam logic [7:0] RST_SECOND_OPERAND = 8'h00;

  // Product byte limit
  localparam logic [15:0] PRODUCT_BYTE_LIMIT = 16'h00ff;

  // Arithmetic operations reported by the core
  typedef enum logic [2:0] {
    DDP_ALU_NONE = 3'b000,
    DDP_ALU_ADD = 3'b001,
    DDP_ALU_ADDC = 3'b010,
    DDP_ALU_SUBB = 3'b011,
    DDP_ALU_MUL = 3'b100,
    DDP_ALU_DIV = 3'b101
  } ddp_alu_op_t;

  // Data pointer operations issued by the core
  typedef enum logic [1:0] {
    DDP_PTR_NONE = 2'b00,
    DDP_PTR_LOAD = 2'b01,
    DDP_PTR_INC = 2'b10
  } ddp_ptr_op_t;

  // Register access from the core in the special-function space
  typedef struct packed {
    logic wr;
    logic inc;
    logic bit_wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_val;
  } ddp_sfr_req_t;

  // Arithmetic request: operands and operation
  typedef struct packed {
    ddp_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } ddp_alu_req_t;

  // Data pointer request
  typedef struct packed {
    ddp_ptr_op_t op;
    logic [15:0] value;
  } ddp_ptr_req_t;

endpackage : ddp_pkg

// ==== design/ddp_regfile.sv ====
// Register file holding two data pointers, their select bit, stack pointer,
// accumulator, second operand register and the program status word.
// Assumes the core issues at most one register access, one arithmetic result
// and one pointer operation per enabled clock, all synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - First pointer: low byte at 0x82, high byte at 0x83.
// - Second pointer: low byte at 0x84, high byte at 0x85.
// - Select register 0x86 bit 0 picks first (0) or second (1) pointer.
// - Only bit 0 of the select register does anything; others read zero.
// - All pointer instructions act on the currently selected pointer.
// - Incrementing the select register inverts its bit 0.
// - Stack pointer byte access only; status, accumulator, operand bit addressable.
// - Carry flag bit 7 set on carry out of bit 7, else cleared.
// - Multiply and divide always clear the carry flag.
// - Nibble carry bit 6 set on nibble carry or borrow, else cleared.
// - Status bits 5 and 1 are plain firmware storage.
// - Status bits 4:3 pick working register bank base 0x00, 0x08, 0x10, 0x18.
// - Overflow bit 2 set on signed overflow of a sum.
// - After multiply, overflow set exactly when product exceeds 0xff.
// - After divide, overflow set exactly when divisor was zero.
// - Status bit 0 is the odd parity of the accumulator.
module ddp_regfile (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire ddp_pkg::ddp_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire ddp_pkg::ddp_alu_req_t alu_req,
  input wire ddp_pkg::ddp_ptr_req_t ptr_req,
  output logic [15:0] data_pointer,
  output logic [7:0] stack_pointer,
  output logic [7:0] status_word,
  output logic [7:0] main_work_register,
  output logic [7:0] second_operand_register,
  output logic [4:0] bank_base
);
  import ddp_pkg::*;

  logic [15:0] first_pointer_q;
  logic [15:0] second_pointer_q;
  logic pointer_choice_q;
  logic [7:0] stack_pointer_q;
  logic [7:0] main_work_q;
  logic [7:0] second_operand_q;
  logic [7:0] status_q;
  logic parity;
  logic [7:0] status_view;
  logic [7:0] read_value;
  logic mapped;
  logic bit_capable;
  logic [7:0] bit_reg_addr;
  logic [2:0] bit_index;
  logic [7:0] bit_reg_value;
  logic [7:0] byte_write_value;
  logic [7:0] bit_write_value;
  logic byte_we;
  logic bit_we;
  logic [7:0] reg_we_addr;
  logic [7:0] reg_we_value;
  logic reg_we;
  logic [15:0] active_pointer;
  logic [15:0] pointer_next;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [15:0] product;
  logic [7:0] quotient;
  logic [7:0] remainder;
  logic carry_in;
  logic arith_add;
  logic arith_sub;
  logic arith_mul;
  logic arith_div;

  // Parity of the accumulator, recomputed every cycle
  assign parity = ^main_work_q;

  // Status word as seen by software and the core
  always_comb
  begin
    status_view = status_q;
    status_view[POS_PARITY] = parity;
  end

  // Read decode of the special-function space
  always_comb
  begin
    read_value = 8'h00;
    mapped = 1'b1;
    case (sfr_req.addr)
      ADDR_STACK_POINTER: read_value = stack_pointer_q;
      ADDR_POINTER0_LOW_BYTE: read_value = first_pointer_q[7:0];
      ADDR_POINTER0_HIGH_BYTE: read_value = first_pointer_q[15:8];
      ADDR_POINTER1_LOW_BYTE: read_value = second_pointer_q[7:0];
      ADDR_POINTER1_HIGH_BYTE: read_value = second_pointer_q[15:8];
      ADDR_POINTER_CHOICE_REG: read_value = {7'h00, pointer_choice_q};
      ADDR_STATUS_WORD: read_value = status_view;
      ADDR_MAIN_WORK_REGISTER: read_value = main_work_q;
      ADDR_SECOND_OPERAND_REGISTER: read_value = second_operand_q;
      default:
      begin
        read_value = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  assign sfr_rdata = read_value;
  assign sfr_hit = mapped;

  // Bit addressing: byte address is the bit address with its low three bits cleared
  assign bit_reg_addr = {sfr_req.addr[7:3], 3'b000};
  assign bit_index = sfr_req.addr[2:0];

  // Only status, accumulator and operand register accept bit writes
  always_comb
  begin
    bit_capable = 1'b0;
    bit_reg_value = 8'h00;
    case (bit_reg_addr)
      ADDR_STATUS_WORD:
      begin
        bit_capable = 1'b1;
        bit_reg_value = status_view;
      end
      ADDR_MAIN_WORK_REGISTER:
      begin
        bit_capable = 1'b1;
        bit_reg_value = main_work_q;
      end
      ADDR_SECOND_OPERAND_REGISTER:
      begin
        bit_capable = 1'b1;
        bit_reg_value = second_operand_q;
      end
      default:
      begin
        bit_capable = 1'b0;
        bit_reg_value = 8'h00;
      end
    endcase
  end

  // Merge a single bit into the addressed byte
  always_comb
  begin
    bit_write_value = bit_reg_value;
    bit_write_value[bit_index] = sfr_req.bit_val;
  end

  // Byte write or increment (increment reads the current value plus one)
  assign byte_write_value = sfr_req.inc ? 8'(read_value + 8'h01) : sfr_req.wdata;
  assign byte_we = sfr_req.wr | sfr_req.inc;
  assign bit_we = sfr_req.bit_wr & ~byte_we & bit_capable;

  // One resolved register write per cycle
  assign reg_we = byte_we | bit_we;
  assign reg_we_addr = bit_we ? bit_reg_addr : sfr_req.addr;
  assign reg_we_value = bit_we ? bit_write_value : byte_write_value;

  // Arithmetic decode
  assign arith_add = (alu_req.op == DDP_ALU_ADD) || (alu_req.op == DDP_ALU_ADDC);
  assign arith_sub = (alu_req.op == DDP_ALU_SUBB);
  assign arith_mul = (alu_req.op == DDP_ALU_MUL);
  assign arith_div = (alu_req.op == DDP_ALU_DIV);
  assign carry_in = (alu_req.op == DDP_ALU_ADD) ? 1'b0 : status_q[POS_UNSIGNED_CARRY];

  // Sum or difference with the nibble carry and full carry
  always_comb
  begin
    if (arith_sub)
    begin
      sum9 = {1'b0, alu_req.a} - {1'b0, alu_req.b} - {8'h00, carry_in};
      nib5 = {1'b0, alu_req.a[3:0]} - {1'b0, alu_req.b[3:0]} - {4'h0, carry_in};
    end
    else
    begin
      sum9 = {1'b0, alu_req.a} + {1'b0, alu_req.b} + {8'h00, carry_in};
      nib5 = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]} + {4'h0, carry_in};
    end
  end

  // Product, quotient and remainder
  assign product = {8'h00, alu_req.a} * {8'h00, alu_req.b};
  always_comb
  begin
    if (alu_req.b == 8'h00)
    begin
      quotient = main_work_q;
      remainder = second_operand_q;
    end
    else
    begin
      quotient = alu_req.a / alu_req.b;
      remainder = alu_req.a % alu_req.b;
    end
  end

  // Active pointer and its next value
  assign active_pointer = pointer_choice_q ? second_pointer_q : first_pointer_q;
  always_comb
  begin
    case (ptr_req.op)
      DDP_PTR_LOAD: pointer_next = ptr_req.value;
      DDP_PTR_INC: pointer_next = 16'(active_pointer + 16'h0001);
      DDP_PTR_NONE: pointer_next = active_pointer;
      default: pointer_next = active_pointer;
    endcase
  end

  // First pointer: register writes, then core pointer operation when selected
  always_ff @(posedge clk)
  begin
    if (srst)
      first_pointer_q <= RST_POINTER;
    else if (ce)
    begin
      if (reg_we && reg_we_addr == ADDR_POINTER0_LOW_BYTE)
        first_pointer_q[7:0] <= reg_we_value;
      if (reg_we && reg_we_addr == ADDR_POINTER0_HIGH_BYTE)
        first_pointer_q[15:8] <= reg_we_value;
      if (ptr_req.op != DDP_PTR_NONE && !pointer_choice_q)
        first_pointer_q <= pointer_next;
    end
  end

  // Second pointer: register writes, then core pointer operation when selected
  always_ff @(posedge clk)
  begin
    if (srst)
      second_pointer_q <= RST_POINTER;
    else if (ce)
    begin
      if (reg_we && reg_we_addr == ADDR_POINTER1_LOW_BYTE)
        second_pointer_q[7:0] <= reg_we_value;
      if (reg_we && reg_we_addr == ADDR_POINTER1_HIGH_BYTE)
        second_pointer_q[15:8] <= reg_we_value;
      if (ptr_req.op != DDP_PTR_NONE && pointer_choice_q)
        second_pointer_q <= pointer_next;
    end
  end

  // Pointer choice: only bit 0 is stored
  always_ff @(posedge clk)
  begin
    if (srst)
      pointer_choice_q <= RST_POINTER_CHOICE[POS_POINTER_CHOICE];
    else if (ce && reg_we && reg_we_addr == ADDR_POINTER_CHOICE_REG)
      pointer_choice_q <= reg_we_value[POS_POINTER_CHOICE];
  end

  // Stack pointer: byte writes and increments only
  always_ff @(posedge clk)
  begin
    if (srst)
      stack_pointer_q <= RST_STACK_POINTER;
    else if (ce && byte_we && sfr_req.addr == ADDR_STACK_POINTER)
      stack_pointer_q <= byte_write_value;
  end

  // Accumulator: arithmetic results win over register writes
  always_ff @(posedge clk)
  begin
    if (srst)
      main_work_q <= RST_MAIN_WORK;
    else if (ce)
    begin
      if (arith_add || arith_sub)
        main_work_q <= sum9[7:0];
      else if (arith_mul)
        main_work_q <= product[7:0];
      else if (arith_div)
        main_work_q <= quotient;
      else if (reg_we && reg_we_addr == ADDR_MAIN_WORK_REGISTER)
        main_work_q <= reg_we_value;
    end
  end

  // Second operand: high product byte or remainder, else register writes
  always_ff @(posedge clk)
  begin
    if (srst)
      second_operand_q <= RST_SECOND_OPERAND;
    else if (ce)
    begin
      if (arith_mul)
        second_operand_q <= product[15:8];
      else if (arith_div)
        second_operand_q <= remainder;
      else if (reg_we && reg_we_addr == ADDR_SECOND_OPERAND_REGISTER)
        second_operand_q <= reg_we_value;
    end
  end

  // Status word: firmware write first, arithmetic flags override their bits
  always_ff @(posedge clk)
  begin
    if (srst)
      status_q <= RST_STATUS_WORD;
    else if (ce)
    begin
      if (reg_we && reg_we_addr == ADDR_STATUS_WORD)
      begin
        status_q[7:1] <= reg_we_value[7:1];
        status_q[POS_PARITY] <= 1'b0;
      end
      if (arith_add || arith_sub)
      begin
        status_q[POS_UNSIGNED_CARRY] <= sum9[8];
        status_q[POS_NIBBLE_CARRY] <= nib5[4];
        if (arith_sub)
          status_q[POS_SIGNED_WRAP] <= (alu_req.a[7] != alu_req.b[7]) &&
            (sum9[7] != alu_req.a[7]);
        else
          status_q[POS_SIGNED_WRAP] <= (alu_req.a[7] == alu_req.b[7]) &&
            (sum9[7] != alu_req.a[7]);
      end
      if (arith_mul)
      begin
        status_q[POS_UNSIGNED_CARRY] <= 1'b0;
        status_q[POS_SIGNED_WRAP] <= product > PRODUCT_BYTE_LIMIT;
      end
      if (arith_div)
      begin
        status_q[POS_UNSIGNED_CARRY] <= 1'b0;
        status_q[POS_SIGNED_WRAP] <= alu_req.b == 8'h00;
      end
    end
  end

  // Outputs toward the core
  assign data_pointer = active_pointer;
  assign stack_pointer = stack_pointer_q;
  assign status_word = status_view;
  assign main_work_register = main_work_q;
  assign second_operand_register = second_operand_q;
  assign bank_base = {status_q[POS_BANK_SELECT_HIGH], status_q[POS_BANK_SELECT_LOW],
    3'b000};

endmodule : ddp_regfile

`default_nettype wire

// ==== test/ddp_regfile_chk.sv ====
// Checker for the pointer and status register file: flag, parity, pointer relations.
// Assumes it is bound to ddp_regfile and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ddp_regfile_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire ddp_pkg::ddp_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire ddp_pkg::ddp_alu_req_t alu_req,
  input wire ddp_pkg::ddp_ptr_req_t ptr_req,
  input wire logic [15:0] data_pointer,
  input wire logic [7:0] stack_pointer,
  input wire logic [7:0] status_word,
  input wire logic [7:0] main_work_register,
  input wire logic [7:0] second_operand_register,
  input wire logic [4:0] bank_base
);
  import ddp_pkg::*;
  logic [8:0] sum9;
  logic op_add, op_mul, op_div, cy_x, ac_x, ov_x, mov_x, dz_x, tog_x, pinc_x;
  // Expected flag values worked out from the operands on the wire
  assign sum9 = {1'b0, alu_req.a} + {1'b0, alu_req.b};
  assign cy_x = sum9[8];
  assign ac_x = ({1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]}) > 5'h0f;
  assign ov_x = (alu_req.a[7] == alu_req.b[7]) && (sum9[7] != alu_req.a[7]);
  assign mov_x = ({8'h00, alu_req.a} * {8'h00, alu_req.b}) > 16'h00ff;
  assign dz_x = alu_req.b == 8'h00;
  assign op_add = ce && alu_req.op == DDP_ALU_ADD;
  assign op_mul = ce && alu_req.op == DDP_ALU_MUL;
  assign op_div = ce && alu_req.op == DDP_ALU_DIV;
  assign tog_x = ce && sfr_req.inc && !sfr_req.wr && !sfr_req.bit_wr
    && sfr_req.addr == ADDR_POINTER_CHOICE_REG;
  assign pinc_x = ce && ptr_req.op == DDP_PTR_INC && !sfr_req.wr && !sfr_req.inc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  add_carry_a: assert property (op_add |=> status_word[7] == $past(cy_x))
    else $error("carry flag wrong after add");
  nibble_carry_a: assert property (op_add |=> status_word[6] == $past(ac_x))
    else $error("nibble carry wrong after add");
  sum_wrap_a: assert property (op_add |=> status_word[2] == $past(ov_x))
    else $error("overflow wrong after add");
  muldiv_carry_a: assert property ((op_mul || op_div) |=> !status_word[7])
    else $error("carry left set by multiply or divide");
  mul_wrap_a: assert property (op_mul |=> status_word[2] == $past(mov_x))
    else $error("overflow wrong after multiply");
  div_wrap_a: assert property (op_div |=> status_word[2] == $past(dz_x))
    else $error("overflow wrong after divide");
  parity_a: assert property (status_word[0] == ^main_work_register)
    else $error("parity bit does not follow accumulator");
  bank_base_a: assert property (bank_base == {status_word[4:3], 3'b000})
    else $error("bank base does not follow status bits");
  choice_bits_a: assert property (
    sfr_req.addr == ADDR_POINTER_CHOICE_REG |-> sfr_rdata[7:1] == 7'h00)
    else $error("unused select bits read nonzero");
  choice_toggle_a: assert property (
    (tog_x ##1 sfr_req.addr == ADDR_POINTER_CHOICE_REG) |->
    sfr_rdata[0] != $past(sfr_rdata[0]))
    else $error("select bit not inverted by increment");
  ptr_inc_a: assert property (
    pinc_x |=> data_pointer == $past(data_pointer) + 16'h0001)
    else $error("active pointer not incremented");
endmodule : ddp_regfile_chk

bind ddp_regfile ddp_regfile_chk u_chk (.clk(clk), .srst(srst), .ce(ce), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .alu_req(alu_req), .ptr_req(ptr_req),
  .data_pointer(data_pointer), .stack_pointer(stack_pointer), .status_word(status_word),
  .main_work_register(main_work_register), .second_operand_register(second_operand_register),
  .bank_base(bank_base));
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the pointer and status register file.
// Assumes the design and its bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import ddp_pkg::*;
  logic clk, srst, ce, sfr_hit;
  ddp_sfr_req_t sfr_req;
  ddp_alu_req_t alu_req;
  ddp_ptr_req_t ptr_req;
  logic [7:0] sfr_rdata, stack_pointer, status_word, acc, bval;
  logic [15:0] data_pointer;
  logic [4:0] bank_base;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  ddp_regfile uut (.clk(clk), .srst(srst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .alu_req(alu_req), .ptr_req(ptr_req), .data_pointer(data_pointer),
    .stack_pointer(stack_pointer), .status_word(status_word), .main_work_register(acc),
    .second_operand_register(bval), .bank_base(bank_base));

  // Core clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // One register strobe, k = {wr, inc, bit_wr}; the address is kept afterwards
  task automatic sfr(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_req <= {k, a, d, d[0]};
    @(posedge clk);
    sfr_req <= {3'b000, a, d, d[0]};
    #1;
  endtask : sfr

  // Combinational read of one address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_req <= {3'b000, a, 8'h00, 1'b0};
    #1;
    `CHK(sfr_rdata, e)
  endtask : rd

  task automatic alu(input ddp_alu_op_t op, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    alu_req <= {op, a, b};
    @(posedge clk);
    alu_req <= '0;
    #1;
  endtask : alu

  task automatic ptr(input ddp_ptr_op_t op, input logic [15:0] v);
    @(posedge clk);
    ptr_req <= {op, v};
    @(posedge clk);
    ptr_req <= '0;
    #1;
  endtask : ptr

  task automatic t_reset();
    logic [7:0] ad [9] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'hd0, 8'he0, 8'hf0};
    foreach (ad[i]) rd(ad[i], 8'h00);
    `CHK(data_pointer, 16'h0000)
    `CHK(sfr_hit, 1'b1)
    rd(8'h80, 8'h00);
    `CHK(sfr_hit, 1'b0)
    $display("reset test done");
  endtask : t_reset

  task automatic t_pointers();
    sfr(3'b100, 8'h82, 8'h11);
    sfr(3'b100, 8'h83, 8'h22);
    sfr(3'b100, 8'h84, 8'h33);
    sfr(3'b100, 8'h85, 8'h44);
    rd(8'h84, 8'h33);
    `CHK(data_pointer, 16'h2211)
    sfr(3'b100, 8'h86, 8'hff);
    rd(8'h86, 8'h01);
    `CHK(data_pointer, 16'h4433)
    ptr(DDP_PTR_INC, 16'h0000);
    `CHK(data_pointer, 16'h4434)
    sfr(3'b010, 8'h86, 8'h00);
    `CHK(data_pointer, 16'h2211)
    ptr(DDP_PTR_LOAD, 16'h00ff);
    ptr(DDP_PTR_INC, 16'h0000);
    rd(8'h83, 8'h01);
    rd(8'h85, 8'h44);
    sfr(3'b010, 8'h86, 8'h00);
    `CHK(data_pointer, 16'h4434)
    $display("pointer test done");
  endtask : t_pointers

  task automatic t_status();
    sfr(3'b001, 8'hd5, 8'h01);
    sfr(3'b001, 8'hd1, 8'h01);
    sfr(3'b001, 8'hd0, 8'h01);
    rd(8'hd0, 8'h22);
    rd(8'hd0, 8'h22);
    sfr(3'b001, 8'he3, 8'h01);
    sfr(3'b001, 8'hf7, 8'h01);
    rd(8'he0, 8'h08);
    rd(8'hf0, 8'h80);
    rd(8'hd0, 8'h23);
    sfr(3'b100, 8'h81, 8'h5a);
    sfr(3'b001, 8'h81, 8'h00);
    rd(8'h81, 8'h5a);
    `CHK(stack_pointer, 8'h5a)
    for (int i = 0; i < 4; i++)
    begin
      sfr(3'b100, 8'hd0, {3'b001, i[1:0], 3'b000});
      `CHK(bank_base, {i[1:0], 3'b000})
    end
    $display("status test done");
  endtask : t_status

  task automatic t_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    alu(DDP_ALU_ADD, a, b);
    `CHK(acc, s[7:0])
    `CHK(status_word[7], s[8])
    `CHK(status_word[6], ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f)
    `CHK(status_word[2], a[7] == b[7] && s[7] != a[7])
    `CHK(status_word[0], ^s[7:0])
  endtask : t_add

  task automatic t_alu();
    t_add(8'h7f, 8'h01);
    t_add(8'h80, 8'h80);
    alu(DDP_ALU_ADDC, 8'h01, 8'h01);
    `CHK({acc, status_word[7]}, 9'h006)
    t_add(8'h12, 8'h34);
    t_add(8'hff, 8'h01);
    alu(DDP_ALU_MUL, 8'h20, 8'h10);
    `CHK({bval, acc, status_word[7], status_word[2]}, 18'h00801)
    alu(DDP_ALU_MUL, 8'h0f, 8'h0f);
    `CHK({bval, acc, status_word[2]}, 17'h001c2)
    t_add(8'hff, 8'h01);
    alu(DDP_ALU_DIV, 8'h64, 8'h07);
    `CHK({bval, acc, status_word[7], status_word[2]}, 18'h00838)
    alu(DDP_ALU_DIV, 8'h33, 8'h00);
    `CHK(status_word[2], 1'b1)
    alu(DDP_ALU_SUBB, 8'h10, 8'h01);
    `CHK({acc, status_word[7:6]}, 10'h03d)
    $display("arithmetic test done");
  endtask : t_alu

  // Clock enable low: strobes, arithmetic and pointer steps are all ignored
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    sfr(3'b100, 8'h81, 8'h33);
    alu(DDP_ALU_ADD, 8'h01, 8'h01);
    ptr(DDP_PTR_INC, 16'h0000);
    `CHK({stack_pointer, acc, bval, status_word, data_pointer}, 48'h5a0f02784434)
    @(posedge clk);
    ce <= 1'b1;
    ptr(DDP_PTR_INC, 16'h0000);
    `CHK(data_pointer, 16'h4435)
    $display("freeze test done");
  endtask : t_freeze

  // Reset, then each scenario in turn
  initial
  begin
    ce = 1'b1;
    srst = 1'b1;
    sfr_req = '0;
    alu_req = '0;
    ptr_req = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_pointers();
    t_status();
    t_alu();
    t_freeze();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
